// File: hw/lsmc_pkg.sv
// Package with the mode controller's constants, register map and types
package lsmc_pkg;
  // Clock rate and timing figures
  localparam int CLK_MHZ = 250;
  localparam int RES_TIME_MS = 4;
  localparam int RES_CYC = RES_TIME_MS * CLK_MHZ * 1000;
  localparam int MSW_TIME_NS = 200;
  localparam int MSW_CYC = (MSW_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int DOM_TIME_US = 20;
  localparam int DOM_CYC = DOM_TIME_US * CLK_MHZ;
  localparam int BUSWK_TIME_US = 30;
  localparam int BUSWK_CYC = BUSWK_TIME_US * CLK_MHZ;
  localparam int LWK_TIME_US = 20;
  localparam int LWK_CYC = LWK_TIME_US * CLK_MHZ;

  // Register bus layout
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFF = 4'h0;
  localparam logic [3:0] STAT_OFF = 4'h4;
  localparam int CTRL_HS_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int ST_MODE_LSB = 0;
  localparam int ST_SRC_LSB = 2;
  localparam int ST_RES_BIT = 4;
  localparam int ST_LH_BIT = 5;
  localparam int ST_SEL_BIT = 6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Synchroniser reset image: en,txd,rst,wdf,hs,wk,ign,brx,bpw,buv,vuv
  localparam logic [10:0] PIN_INIT = 11'h328;

  typedef enum logic [1:0] {M_FAILSAFE, M_NORMAL, M_SILENT, M_SLEEP} lsmc_mode_t;
  typedef enum logic [1:0] {SRC_NONE, SRC_BUS, SRC_LOCAL, SRC_BATT_UV} lsmc_src_t;
endpackage

// File: hw/lsmc_sync.sv
// Two-flop synchroniser bank for the pin inputs
`timescale 1ns/10ps
module lsmc_sync #(
  parameter int W = 11,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= INIT;
      q <= INIT;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// File: hw/lsmc_ctrl.sv
// Operating-mode controller of a LIN system basis chip, with register slave
// How it works
// - After power-up reset the controller starts in Fail-Safe mode by itself.
// - After power-up the reset output is held low for 4 ms.
// - Fail-Safe: regulator and watchdog on, transceiver off, bus recessive.
// - Fail-Safe never drives the bus dominant.
// - Fail-Safe waits for enable high, then enters Normal.
// - Reset line low in Normal or Silent forces Fail-Safe at once.
// - Normal: transceiver on, bus follows transmit data, receive follows bus.
// - Enable falling with transmit data high selects Silent.
// - Silent: transmit off, regulator on, watchdog off, both pins high.
// - Silent: supply undervoltage or watchdog failure pulls reset, enters Fail-Safe.
// - Silent entry ignores bus and local wake levels.
// - Silent and Sleep drop the bus termination, only weak pull-up remains.
// - Enable falling with transmit data low selects Sleep.
// - Sleep: regulator off, reset and receive low, transmit low, rest off.
// - Sleep: bus below pre-wake threshold enables receiver and wake timer.
// - Transmit data stuck low still allows Sleep entry after dominant timeout.
// - Fail-Safe codes the source: bus low/low, local low/high, battery high/low.
// - Battery undervoltage from Normal still lets enable falling pick a low mode.
// - A wake event in Silent or Sleep enters Fail-Safe.
// - The wake source is cleared on entering Normal.
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module lsmc_ctrl import lsmc_pkg::*; #(
  parameter int unsigned RES_CYCLES = RES_CYC,
  parameter int unsigned DOM_CYCLES = DOM_CYC,
  parameter int unsigned BUSWK_CYCLES = BUSWK_CYC,
  parameter int unsigned LWK_CYCLES = LWK_CYC,
  parameter int unsigned MSW_CYCLES = MSW_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic en_in,
  input wire logic txd_in,
  output logic txd_o,
  output logic txd_oe_n,
  output logic rxd_o,
  input wire logic reset_out_n_in,
  output logic reset_out_n_o,
  output logic reset_out_n_oe_n,
  input wire logic watchdog_fail_in,
  input wire logic high_side_control_in,
  input wire logic local_wake_in,
  input wire logic ignition_wake_in,
  input wire logic bus_rx_in,
  input wire logic bus_prewake_in,
  input wire logic battery_uv_in,
  input wire logic vcc_uv_in,
  output logic bus_tx_dom_o,
  output logic transceiver_en_o,
  output logic regulator_en_o,
  output logic watchdog_en_o,
  output logic limp_home_out,
  output logic high_side_out,
  output logic termination_en_o,
  output logic prewake_rx_en_o
);
  localparam int ASRT_WIN = MSW_CYCLES + 2;

  // Counters are 32 bits; zero-length timers cannot work
  if (RES_CYCLES < 8 || MSW_CYCLES < 1 || DOM_CYCLES < 1 ||
      BUSWK_CYCLES < 1 || LWK_CYCLES < 1) begin : g_chk
    $error("lsmc_ctrl: timing parameters out of range");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
    hit = (a[3:2] == off[3:2]);
  endfunction

  logic en_s, txd_s, rst_s, wdf_s, hs_s, wk_s, ign_s, brx_s, bpw_s, buv_s, vuv_s;
  lsmc_sync #(.W(11), .INIT(PIN_INIT)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({en_in, txd_in, reset_out_n_in, watchdog_fail_in, high_side_control_in,
        local_wake_in, ignition_wake_in, bus_rx_in, bus_prewake_in, battery_uv_in,
        vcc_uv_in}),
    .q({en_s, txd_s, rst_s, wdf_s, hs_s, wk_s, ign_s, brx_s, bpw_s, buv_s, vuv_s})
  );

  lsmc_mode_t mode_reg, mode_next;
  lsmc_src_t src_reg, src_next;
  logic [31:0] res_cnt_reg, win_cnt_reg, dom_cnt_reg, bw_cnt_reg, lw_cnt_reg;
  logic en_d_reg, ign_d_reg, brx_d_reg, sel_reg, uvsel_reg, lh_reg;
  logic [31:0] ctrl_reg;

  // Edge and condition decoding
  wire en_fall = en_d_reg & ~en_s;
  wire ign_rise = ~ign_d_reg & ign_s;
  wire brx_rise = ~brx_d_reg & brx_s;
  wire res_busy = (res_cnt_reg != 32'h0000_0000);
  wire low_pwr = (mode_reg == M_SILENT) || (mode_reg == M_SLEEP);
  wire dom_tmo = (dom_cnt_reg >= DOM_CYCLES);
  // Bus wake in Silent only counts when transmit data is high
  wire bus_ok = (mode_reg == M_SLEEP) || txd_s;
  wire prewake_next = low_pwr & bpw_s;
  wire bus_wake = low_pwr & bus_ok & brx_rise & (bw_cnt_reg >= BUSWK_CYCLES);
  wire lw_fire = ~wk_s & (lw_cnt_reg == LWK_CYCLES - 1);
  wire loc_wake = low_pwr & (lw_fire | ign_rise);
  // select allowed from Normal or battery-undervoltage Fail-Safe
  wire sel_ok = (mode_reg == M_NORMAL) || ((mode_reg == M_FAILSAFE) && uvsel_reg);
  // window opens regardless of bus or wake pin level
  wire sel_start = en_fall & sel_ok & ~res_busy & ~sel_reg;
  wire sel_end = sel_reg & (win_cnt_reg == 32'h0000_0001);
  wire sil_fail = (mode_reg == M_SILENT) & (vuv_s | wdf_s);
  wire nor_fail = (mode_reg == M_NORMAL) & (vuv_s | wdf_s);
  wire wake_any = bus_wake | loc_wake;
  // Regulator restart or supervisor fault reloads the reset timer
  wire res_load = sil_fail | nor_fail | ((mode_reg == M_SLEEP) & (wake_any | en_s));

  // Mode sequencing
  always_comb begin
    mode_next = mode_reg;
    src_next = src_reg;
    case (mode_reg)
      M_FAILSAFE: begin
        // enable high after reset time, battery back
        if (en_s && rst_s && !res_busy && !sel_reg && !buv_s) begin
          mode_next = M_NORMAL;
          src_next = SRC_NONE;
        end
      end
      M_NORMAL: begin
        if (!rst_s || nor_fail) begin
          mode_next = M_FAILSAFE;
        end else if (buv_s) begin
          mode_next = M_FAILSAFE;
          src_next = SRC_BATT_UV;
        end
      end
      M_SILENT: begin
        if (!rst_s || sil_fail || en_s) begin
          mode_next = M_FAILSAFE;
        end
      end
      M_SLEEP: begin
        if (en_s) begin
          mode_next = M_FAILSAFE;
        end
      end
      default: mode_next = M_FAILSAFE;
    endcase
    if (wake_any) begin
      mode_next = M_FAILSAFE;
      src_next = bus_wake ? SRC_BUS : SRC_LOCAL;
    end
    if (sel_end && sel_ok && mode_next == mode_reg) begin
      // low selects Sleep, high selects Silent
      mode_next = txd_s ? M_SILENT : M_SLEEP;
    end
  end

  // State registers; reset lands in Fail-Safe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= M_FAILSAFE;
      src_reg <= SRC_NONE;
      en_d_reg <= 1'b0;
      ign_d_reg <= 1'b0;
      brx_d_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      src_reg <= src_next;
      en_d_reg <= en_s;
      ign_d_reg <= ign_s;
      brx_d_reg <= brx_s;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_cnt_reg <= RES_CYCLES;
    end else if (res_load) begin
      res_cnt_reg <= RES_CYCLES;
    end else if (res_busy) begin
      res_cnt_reg <= res_cnt_reg - 32'h0000_0001;
    end
  end

  // Select window; aborted if the mode is left, except into battery-undervoltage Fail-Safe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_reg <= 1'b0;
      win_cnt_reg <= 32'h0000_0000;
    end else if (sel_start) begin
      sel_reg <= 1'b1;
      win_cnt_reg <= MSW_CYCLES;
    end else if (sel_end || !sel_ok) begin
      sel_reg <= 1'b0;
      win_cnt_reg <= 32'h0000_0000;
    end else if (sel_reg) begin
      win_cnt_reg <= win_cnt_reg - 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uvsel_reg <= 1'b0;
    end else if (mode_reg == M_NORMAL && mode_next == M_FAILSAFE) begin
      uvsel_reg <= (src_next == SRC_BATT_UV);
    end else if (mode_reg != M_FAILSAFE) begin
      uvsel_reg <= 1'b0;
    end
  end

  // dominant timeout blocks the driver, never the Sleep request
  always_ff @(posedge aclk) begin
    if (!aresetn || txd_s) begin
      dom_cnt_reg <= 32'h0000_0000;
    end else if (!dom_tmo) begin
      dom_cnt_reg <= dom_cnt_reg + 32'h0000_0001;
    end
  end

  // bus wake timer runs only with the pre-wake receiver on
  always_ff @(posedge aclk) begin
    if (!aresetn || brx_s || !prewake_next) begin
      bw_cnt_reg <= 32'h0000_0000;
    end else if (bw_cnt_reg < BUSWK_CYCLES) begin
      bw_cnt_reg <= bw_cnt_reg + 32'h0000_0001;
    end
  end

  // Local wake low time; saturates so a held-low pin fires only once
  always_ff @(posedge aclk) begin
    if (!aresetn || wk_s) begin
      lw_cnt_reg <= 32'h0000_0000;
    end else if (lw_cnt_reg < LWK_CYCLES) begin
      lw_cnt_reg <= lw_cnt_reg + 32'h0000_0001;
    end
  end

  // Limp-home latches a watchdog failure, holds in Silent, off in Sleep
  always_ff @(posedge aclk) begin
    if (!aresetn || mode_reg == M_SLEEP) begin
      lh_reg <= 1'b0;
    end else if (wdf_s && (mode_reg == M_FAILSAFE || mode_reg == M_NORMAL)) begin
      lh_reg <= 1'b1;
    end
  end

  // Pin output values per mode
  wire m_fs = (mode_next == M_FAILSAFE);
  wire m_nor = (mode_next == M_NORMAL);
  wire m_sil = (mode_next == M_SILENT);
  wire m_slp = (mode_next == M_SLEEP);
  wire src_txd_hi = (src_next == SRC_BATT_UV) || (src_next == SRC_NONE);
  wire src_rxd_hi = (src_next == SRC_LOCAL) || (src_next == SRC_NONE);
  // bus follows transmit data; only Normal drives dominant
  wire tx_dom_next = m_nor & ~txd_s & ~dom_tmo;
  wire rxd_next = m_nor ? brx_s : (m_fs ? src_rxd_hi : m_sil);
  wire txd_oe_next = ~(m_fs | m_slp);
  wire hs_next = ~m_slp & hs_s & ctrl_reg[CTRL_HS_BIT];
  wire res_drive = res_load | (res_busy & ~res_cnt_reg[31] & (res_cnt_reg != 32'h0000_0001));

  // Registered pin outputs; per mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txd_o <= 1'b1;
      txd_oe_n <= 1'b0;
      rxd_o <= 1'b1;
      reset_out_n_oe_n <= 1'b0;
      bus_tx_dom_o <= 1'b0;
      transceiver_en_o <= 1'b0;
      regulator_en_o <= 1'b1;
      watchdog_en_o <= 1'b1;
      limp_home_out <= 1'b0;
      high_side_out <= 1'b0;
      termination_en_o <= 1'b1;
      prewake_rx_en_o <= 1'b0;
    end else begin
      txd_o <= m_fs & src_txd_hi;
      txd_oe_n <= txd_oe_next;
      rxd_o <= rxd_next;
      reset_out_n_oe_n <= ~(res_drive | m_slp);
      bus_tx_dom_o <= tx_dom_next;
      transceiver_en_o <= m_nor;
      regulator_en_o <= ~m_slp;
      watchdog_en_o <= m_fs | m_nor;
      limp_home_out <= lh_reg & ~m_slp;
      high_side_out <= hs_next;
      termination_en_o <= m_fs | m_nor;
      prewake_rx_en_o <= prewake_next;
    end
  end
  // Open-drain: only ever pulls low
  assign reset_out_n_o = 1'b0;

  // Register slave: address and data taken in either order
  logic aw_full_reg, w_full_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire do_wr = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire wr_ctrl = do_wr & hit(aw_addr_reg, CTRL_OFF);
  wire wr_known = wr_ctrl | hit(aw_addr_reg, STAT_OFF);
  wire rd_ctrl = hit(s_axi_araddr, CTRL_OFF);
  wire rd_stat = hit(s_axi_araddr, STAT_OFF);
  wire [31:0] stat_word = {25'h000_0000, sel_reg, lh_reg, res_busy, src_reg, mode_reg};
  wire [31:0] rd_word = rd_ctrl ? ctrl_reg : (rd_stat ? stat_word : 32'h0000_0000);

  // Write side; status is read-only and ignores writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      ctrl_reg <= CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_known || hit(aw_addr_reg, STAT_OFF)) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl && w_strb_reg[0]) begin
        ctrl_reg[CTRL_HS_BIT] <= w_data_reg[CTRL_HS_BIT];
      end
    end
  end

  // Read side, one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= (rd_ctrl || rd_stat) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on mode sequencing and pin levels
  sequence s_select;
    mode_reg == M_NORMAL && sel_start && rst_s && !buv_s && !vuv_s && !wdf_s;
  endsequence
  property p_power_up;
    @(posedge aclk) disable iff (!aresetn)
      $rose(aresetn) |-> mode_reg == M_FAILSAFE && !reset_out_n_oe_n[*8];
  endproperty
  a_power_up: assert property (p_power_up) else $error("no reset hold at power-up");
  property p_fs_pins;
    @(posedge aclk) disable iff (!aresetn)
      $past(mode_next) == M_FAILSAFE |-> regulator_en_o && watchdog_en_o &&
        !transceiver_en_o && !bus_tx_dom_o && !txd_oe_n;
  endproperty
  a_fs_pins: assert property (p_fs_pins) else $error("fail-safe pin levels wrong");
  property p_to_normal;
    @(posedge aclk) disable iff (!aresetn)
      mode_reg == M_FAILSAFE && en_s && rst_s && !res_busy && !sel_reg && !wake_any && !buv_s
        |=> mode_reg == M_NORMAL && src_reg == SRC_NONE;
  endproperty
  a_to_normal: assert property (p_to_normal) else $error("enable high ignored");
  property p_rst_pin;
    @(posedge aclk) disable iff (!aresetn)
      mode_reg == M_NORMAL && !rst_s |=> mode_reg == M_FAILSAFE;
  endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("reset low not honoured");
  property p_select;
    @(posedge aclk) disable iff (!aresetn)
      s_select ##1 (sel_reg && mode_reg == M_NORMAL && rst_s)[*1]
        |-> ##[1:ASRT_WIN] (mode_reg != M_NORMAL);
  endproperty
  a_select: assert property (p_select) else $error("select window did not end");
  property p_silent_pins;
    @(posedge aclk) disable iff (!aresetn)
      $past(mode_next) == M_SILENT |-> rxd_o && txd_oe_n && regulator_en_o &&
        !watchdog_en_o && !termination_en_o;
  endproperty
  a_silent_pins: assert property (p_silent_pins) else $error("silent pins wrong");
  property p_silent_fail;
    @(posedge aclk) disable iff (!aresetn)
      mode_reg == M_SILENT && vuv_s |=> mode_reg == M_FAILSAFE ##0 !reset_out_n_oe_n;
  endproperty
  a_silent_fail: assert property (p_silent_fail) else $error("silent fault missed");
  property p_sleep_pins;
    @(posedge aclk) disable iff (!aresetn)
      $past(mode_next) == M_SLEEP |-> !regulator_en_o && !rxd_o && !txd_o &&
        !reset_out_n_oe_n && !high_side_out && !limp_home_out;
  endproperty
  a_sleep_pins: assert property (p_sleep_pins) else $error("sleep pins wrong");
  property p_ign_wake;
    @(posedge aclk) disable iff (!aresetn)
      mode_reg == M_SLEEP && ign_rise |=> mode_reg == M_FAILSAFE && src_reg == SRC_LOCAL
        ##1 !txd_o && rxd_o;
  endproperty
  a_ign_wake: assert property (p_ign_wake) else $error("local wake not coded");
endmodule

// File: verification/lsmc_host.sv
// Host model: drives the enable pin, transmit data and the watchdog failure line
`timescale 1ns/10ps
module lsmc_host #(
  parameter int HOLD = 8
) (
  input wire logic aclk,
  output logic en,
  output logic txd,
  output logic wd_fail
);
  // Enable low, transmit data idle high at power-up
  initial begin
    en = 1'b0;
    txd = 1'b1;
    wd_fail = 1'b0;
  end

  task automatic set_pins(input logic e, input logic t);
    en <= e;
    txd <= t;
  endtask

  task automatic select_mode(input logic t, input bit late);
    set_pins(1'b0, late ? ~t : t);
    if (late) begin
      @(posedge aclk);
      txd <= t;
    end
    // Hold past the window plus the synchroniser delay
    repeat (HOLD) @(posedge aclk);
  endtask
endmodule

// File: verification/tb_lsmc_ctrl.sv
// Testbench: mode sequencing of the controller through its pins and registers
`timescale 1ns/10ps
module tb_lsmc_ctrl import lsmc_pkg::*; ;
  localparam int unsigned RES_T = 100;
  localparam int unsigned MSW_T = 4;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic en_in, txd_in, txd_o, txd_oe_n, rxd_o, reset_out_n_in, reset_out_n_o, reset_out_n_oe_n;
  logic watchdog_fail_in, high_side_control_in, local_wake_in, ignition_wake_in, bus_rx_in;
  logic bus_prewake_in, battery_uv_in, vcc_uv_in, bus_tx_dom_o, transceiver_en_o;
  logic regulator_en_o, watchdog_en_o, limp_home_out, high_side_out, termination_en_o;
  logic prewake_rx_en_o, ext_rst_n, host_txd;
  int bad_count, checked, cyc;
  wire [7:0] pins = {transceiver_en_o, regulator_en_o, watchdog_en_o, termination_en_o,
    txd_oe_n, txd_o, rxd_o, bus_tx_dom_o};

  // Shared pins: device drive wins on transmit data, reset wire is pulled up
  assign txd_in = txd_oe_n ? host_txd : txd_o;
  assign reset_out_n_in = (reset_out_n_oe_n | reset_out_n_o) & ext_rst_n;

  // Short counts keep the run brief
  lsmc_ctrl #(.RES_CYCLES(RES_T), .DOM_CYCLES(20), .BUSWK_CYCLES(10), .LWK_CYCLES(10),
    .MSW_CYCLES(MSW_T)) lsmc_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .en_in, .txd_in, .txd_o, .txd_oe_n, .rxd_o,
    .reset_out_n_in, .reset_out_n_o, .reset_out_n_oe_n, .watchdog_fail_in,
    .high_side_control_in, .local_wake_in, .ignition_wake_in, .bus_rx_in, .bus_prewake_in,
    .battery_uv_in, .vcc_uv_in, .bus_tx_dom_o, .transceiver_en_o, .regulator_en_o,
    .watchdog_en_o, .limp_home_out, .high_side_out, .termination_en_o, .prewake_rx_en_o);
  lsmc_host #(.HOLD(MSW_T + 4)) lsmc_host_i (.aclk(aclk), .en(en_in), .txd(host_txd),
    .wd_fail(watchdog_fail_in));

  // Clock and hang guard
  initial aclk = 1'b0;
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize();
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: mismatch, got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_pins(input logic [7:0] e, input logic [7:0] m);
    chk(pins & m, e & m);
  endtask

  // Write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // One idle edge so the next call never reassigns in this step
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [3:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Poll the mode field, bounded, then let the pin outputs settle
  task automatic wait_mode(input lsmc_mode_t m);
    int n;
    n = 0;
    do begin
      axi_rd(STAT_OFF);
      n++;
    end while (rd[1:0] !== m && n < 300);
    chk(rd[1:0], m);
    repeat (2) @(posedge aclk);
  endtask

  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {high_side_control_in, ignition_wake_in, bus_prewake_in, battery_uv_in, vcc_uv_in} = '0;
    {local_wake_in, bus_rx_in, ext_rst_n} = 3'h7;
    bad_count = 0;
    checked = 0;
    cyc = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_pins(8'h76, 8'hff);
    chk({reset_out_n_oe_n, limp_home_out}, 2'b00);
    lsmc_host_i.set_pins(1'b1, 1'b1);
    // High-side gate and register map while the reset time runs
    axi_rd(CTRL_OFF);
    chk({rr, rd}, {RESP_OKAY, CTRL_RST});
    high_side_control_in <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(high_side_out, 1'b1);
    axi_wr(CTRL_OFF, 32'h0000_0000);
    repeat (4) @(posedge aclk);
    chk(high_side_out, 1'b0);
    axi_wr(CTRL_OFF, 32'h0000_0001);
    axi_rd(4'h8);
    chk({rr, rd}, {RESP_SLVERR, 32'h0000_0000});
    axi_wr(STAT_OFF, 32'hffff_ffff);
    chk(rr, RESP_OKAY);
    repeat (30) @(posedge aclk);
    chk(reset_out_n_oe_n, 1'b0);
    axi_rd(STAT_OFF);
    chk(rd[1:0], M_FAILSAFE);
    wait_mode(M_NORMAL);
    chk(reset_out_n_oe_n, 1'b1);
    chk_pins(8'hfa, 8'hfb);
    // Normal traffic: bus follows transmit data, receive follows bus
    lsmc_host_i.set_pins(1'b1, 1'b0);
    bus_rx_in <= 1'b0;
    repeat (6) @(posedge aclk);
    chk({bus_tx_dom_o, rxd_o}, 2'b10);
    lsmc_host_i.set_pins(1'b1, 1'b1);
    bus_rx_in <= 1'b1;
    // Reset wire pulled low from outside
    ext_rst_n <= 1'b0;
    repeat (8) @(posedge aclk);
    chk({transceiver_en_o, bus_tx_dom_o}, 2'b00);
    ext_rst_n <= 1'b1;
    wait_mode(M_NORMAL);
    // Silent entry with the bus held dominant
    bus_rx_in <= 1'b0;
    lsmc_host_i.select_mode(1'b1, 1'b0);
    wait_mode(M_SILENT);
    chk_pins(8'h4a, 8'hfb);
    bus_rx_in <= 1'b1;
    // Local wake from Silent
    local_wake_in <= 1'b0;
    repeat (20) @(posedge aclk);
    local_wake_in <= 1'b1;
    wait_mode(M_FAILSAFE);
    chk(rd[3:2], SRC_LOCAL);
    chk_pins(8'h72, 8'hff);
    lsmc_host_i.set_pins(1'b1, 1'b1);
    wait_mode(M_NORMAL);
    chk(rd[3:2], SRC_NONE);
    // Late transmit data still picks Silent, then supply drop
    lsmc_host_i.select_mode(1'b1, 1'b1);
    wait_mode(M_SILENT);
    vcc_uv_in <= 1'b1;
    repeat (6) @(posedge aclk);
    vcc_uv_in <= 1'b0;
    chk({reset_out_n_oe_n, watchdog_en_o}, 2'b01);
    lsmc_host_i.set_pins(1'b1, 1'b1);
    wait_mode(M_NORMAL);
    // Watchdog failure in Normal latches limp-home and pulls reset
    lsmc_host_i.wd_fail <= 1'b1;
    repeat (6) @(posedge aclk);
    lsmc_host_i.wd_fail <= 1'b0;
    chk({limp_home_out, reset_out_n_oe_n, transceiver_en_o}, 3'b100);
    wait_mode(M_NORMAL);
    chk(limp_home_out, 1'b1);
    // Transmit data stuck low, then Sleep
    lsmc_host_i.set_pins(1'b1, 1'b0);
    repeat (30) @(posedge aclk);
    chk(bus_tx_dom_o, 1'b0);
    lsmc_host_i.select_mode(1'b0, 1'b0);
    wait_mode(M_SLEEP);
    chk_pins(8'h00, 8'hff);
    chk({reset_out_n_oe_n, limp_home_out, high_side_out}, 3'b000);
    // Bus wake from Sleep
    bus_prewake_in <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(prewake_rx_en_o, 1'b1);
    bus_rx_in <= 1'b0;
    repeat (15) @(posedge aclk);
    bus_rx_in <= 1'b1;
    wait_mode(M_FAILSAFE);
    bus_prewake_in <= 1'b0;
    chk(rd[3:2], SRC_BUS);
    chk_pins(8'h70, 8'hff);
    lsmc_host_i.set_pins(1'b1, 1'b1);
    wait_mode(M_NORMAL);
    // Ignition wake from Sleep
    lsmc_host_i.select_mode(1'b0, 1'b0);
    wait_mode(M_SLEEP);
    ignition_wake_in <= 1'b1;
    wait_mode(M_FAILSAFE);
    chk({rd[3:2], txd_o, rxd_o}, {SRC_LOCAL, 2'b01});
    ignition_wake_in <= 1'b0;
    lsmc_host_i.set_pins(1'b1, 1'b1);
    wait_mode(M_NORMAL);
    // Battery undervoltage in Normal, then a low-power pick
    battery_uv_in <= 1'b1;
    wait_mode(M_FAILSAFE);
    chk(rd[3:2], SRC_BATT_UV);
    chk_pins(8'h74, 8'hff);
    lsmc_host_i.select_mode(1'b1, 1'b0);
    battery_uv_in <= 1'b0;
    wait_mode(M_SILENT);
    summarize();
  end
endmodule
